// file: rtl/rgx_input_crossbar.sv
// receive-side pin crossbar: per-function pin select registers and routing
`timescale 1ns/1ps
`default_nettype none
`include "rgx_defines.svh"
module rgx_input_crossbar #(
  parameter int NUM_GPIO = 5,
  parameter int NUM_FUNC = 11
) (
  input  wire logic                i_clock,
  input  wire logic                i_srst,
  // register port
  input  wire logic [14:0]         i_reg_addr,
  input  wire logic                i_reg_wr,
  input  wire logic [7:0]          i_reg_wdata,
  output logic      [7:0]          o_reg_rdata,
  // pins, gpio6..gpio10 and the sync input pair
  input  wire logic [NUM_GPIO-1:0] i_gpio,
  input  wire logic                i_sync_in_positive_pin,
  input  wire logic                i_sync_in_negative_pin,
  // hop source choice and register-driven hop values
  input  wire logic                i_rx_hop_pin_mode,
  input  wire logic [1:0]          i_rx_hop_page_reg,
  input  wire logic [3:0]          i_rx_hop_word_reg,
  // raw fast detect flags to be gated
  input  wire logic [3:0]          i_fast_detect_raw,
  // routed functions
  output logic      [1:0]          o_rx_hop_page,
  output logic      [3:0]          o_rx_hop_word,
  output logic                     o_fast_detect_update_gate,
  output logic      [3:0]          o_fast_detect,
  output logic      [1:0]          o_eq_profile_sel,
  output logic                     o_adc1_power_control,
  output logic                     o_adc3_power_control
);
  localparam int NUM_SRC = NUM_GPIO + 2;

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  if (NUM_GPIO != 5 || NUM_FUNC != 11) begin : g_bad_param
    $error("crossbar code map serves exactly five gpio pins and eleven functions");
  end

  // ------------------------------------------------------------
  // address and code decode
  // ------------------------------------------------------------
  function automatic logic [14:0] func_addr(input int idx);
    unique case (rgx_pkg::rgx_func_t'(idx))
      rgx_pkg::RGX_F_HOP_WORD_B0: func_addr = `RGX_ADDR_HOP_WORD_B0;
      rgx_pkg::RGX_F_HOP_WORD_B1: func_addr = `RGX_ADDR_HOP_WORD_B1;
      rgx_pkg::RGX_F_HOP_WORD_B2: func_addr = `RGX_ADDR_HOP_WORD_B2;
      rgx_pkg::RGX_F_HOP_WORD_B3: func_addr = `RGX_ADDR_HOP_WORD_B3;
      rgx_pkg::RGX_F_HOP_PAGE_B1: func_addr = `RGX_ADDR_HOP_PAGE_B1;
      rgx_pkg::RGX_F_HOP_PAGE_B0: func_addr = `RGX_ADDR_HOP_PAGE_B0;
      rgx_pkg::RGX_F_FD_GATE:     func_addr = `RGX_ADDR_FD_GATE;
      rgx_pkg::RGX_F_EQ_B0:       func_addr = `RGX_ADDR_EQ_B0;
      rgx_pkg::RGX_F_EQ_B1:       func_addr = `RGX_ADDR_EQ_B1;
      rgx_pkg::RGX_F_ADC1_PWR:    func_addr = `RGX_ADDR_ADC1_PWR;
      default:                    func_addr = `RGX_ADDR_ADC3_PWR;
    endcase
  endfunction

  // code to pin, undocumented code reads as low
  function automatic logic pick_pin(input logic [7:0] code, input logic [NUM_SRC-1:0] src);
    logic [7:0] off;
    off = code - `RGX_CODE_FIRST_GPIO;
    if (code >= `RGX_CODE_FIRST_GPIO && code <= `RGX_CODE_SYNC_NEG) begin
      pick_pin = src[off[2:0]];
    end else begin
      pick_pin = 1'b0;
    end
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [NUM_SRC-1:0] pins_raw;
  logic [NUM_SRC-1:0] pins_s;
  assign pins_raw = {i_sync_in_negative_pin, i_sync_in_positive_pin, i_gpio};

  rgx_pin_sync #(.WIDTH(NUM_SRC)) u_sync (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_async (pins_raw),
    .o_sync  (pins_s)
  );

  // ------------------------------------------------------------
  // select registers and crossbar
  // ------------------------------------------------------------
  logic [7:0]          sel_q [NUM_FUNC];
  logic [NUM_FUNC-1:0] hit;
  logic [NUM_FUNC-1:0] func_d;
  logic [NUM_FUNC-1:0] func_q;
  logic [7:0]          rdata_d;
  logic [7:0]          rdata_q;

  for (genvar f = 0; f < NUM_FUNC; f++) begin : g_func
    assign hit[f] = (i_reg_addr == func_addr(f));
    // one select per function, written by software alone
    always_ff @(posedge i_clock) begin
      if (i_srst) begin
        sel_q[f] <= `RGX_SEL_RESET;
      end else if (i_reg_wr && hit[f]) begin
        sel_q[f] <= i_reg_wdata;
      end
    end
    assign func_d[f] = pick_pin(sel_q[f], pins_s);
  end

  always_comb begin
    rdata_d = `RGX_READ_UNMAPPED;
    for (int f = 0; f < NUM_FUNC; f++) begin
      if (hit[f]) begin
        rdata_d = sel_q[f];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      func_q  <= '0;
      rdata_q <= `RGX_READ_UNMAPPED;
    end else begin
      func_q  <= func_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // function outputs
  // ------------------------------------------------------------
  logic [1:0] page_pin;
  logic [3:0] word_pin;
  logic [3:0] fd_q;
  assign page_pin = {func_q[rgx_pkg::RGX_F_HOP_PAGE_B1], func_q[rgx_pkg::RGX_F_HOP_PAGE_B0]};
  // highest hop input is the msb
  assign word_pin = {func_q[rgx_pkg::RGX_F_HOP_WORD_B3], func_q[rgx_pkg::RGX_F_HOP_WORD_B2],
                     func_q[rgx_pkg::RGX_F_HOP_WORD_B1], func_q[rgx_pkg::RGX_F_HOP_WORD_B0]};

  // pins or register values drive the hop, the choice is a level input
  assign o_rx_hop_page = i_rx_hop_pin_mode ? page_pin : i_rx_hop_page_reg;
  assign o_rx_hop_word = i_rx_hop_pin_mode ? word_pin : i_rx_hop_word_reg;

  assign o_fast_detect_update_gate = func_q[rgx_pkg::RGX_F_FD_GATE];
  assign o_eq_profile_sel = {func_q[rgx_pkg::RGX_F_EQ_B1], func_q[rgx_pkg::RGX_F_EQ_B0]};
  assign o_adc1_power_control = func_q[rgx_pkg::RGX_F_ADC1_PWR];
  assign o_adc3_power_control = func_q[rgx_pkg::RGX_F_ADC3_PWR];
  assign o_reg_rdata = rdata_q;
  assign o_fast_detect = fd_q;

  // fast detect flags hold while the gate is low
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      fd_q <= '0;
    end else if (func_q[rgx_pkg::RGX_F_FD_GATE]) begin
      fd_q <= i_fast_detect_raw;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_undoc_code_low: assert property (@(posedge i_clock) disable iff (i_srst)
    (sel_q[0] < `RGX_CODE_FIRST_GPIO || sel_q[0] > `RGX_CODE_SYNC_NEG) |=> !func_q[0])
    else $error("undocumented code did not hold the function low");

  a_gpio_route: assert property (@(posedge i_clock) disable iff (i_srst)
    (sel_q[rgx_pkg::RGX_F_ADC1_PWR] == `RGX_CODE_FIRST_GPIO)
      |=> (o_adc1_power_control == $past(pins_s[0])))
    else $error("adc1 power did not follow gpio6");

  a_sync_neg_route: assert property (@(posedge i_clock) disable iff (i_srst)
    (sel_q[rgx_pkg::RGX_F_ADC3_PWR] == `RGX_CODE_SYNC_NEG)
      |=> (o_adc3_power_control == $past(pins_s[NUM_SRC-1])))
    else $error("adc3 power did not follow negative sync pin");

  a_sel_write: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_reg_wr && i_reg_addr == `RGX_ADDR_FD_GATE)
      |=> (sel_q[rgx_pkg::RGX_F_FD_GATE] == $past(i_reg_wdata)))
    else $error("select write not stored");

  a_page_order: assert property (@(posedge i_clock) disable iff (i_srst)
    (sel_q[rgx_pkg::RGX_F_HOP_PAGE_B1] == `RGX_CODE_SYNC_POS) ##1 i_rx_hop_pin_mode
      |-> (o_rx_hop_page[1] == $past(pins_s[NUM_SRC-2])))
    else $error("hop page bit order wrong");

  a_word_msb: assert property (@(posedge i_clock) disable iff (i_srst)
    (sel_q[rgx_pkg::RGX_F_HOP_WORD_B3] == `RGX_CODE_FIRST_GPIO) ##1 i_rx_hop_pin_mode
      |-> (o_rx_hop_word[3] == $past(pins_s[0])))
    else $error("hop word msb wrong");

  a_fd_hold: assert property (@(posedge i_clock) disable iff (i_srst)
    !o_fast_detect_update_gate |=> $stable(o_fast_detect))
    else $error("fast detect changed while gated");

  a_hop_reg_mode: assert property (@(posedge i_clock) disable iff (i_srst)
    !i_rx_hop_pin_mode |-> (o_rx_hop_word == i_rx_hop_word_reg))
    else $error("register hop word not used");

  a_eq_order: assert property (@(posedge i_clock) disable iff (i_srst)
    (sel_q[rgx_pkg::RGX_F_EQ_B1] == `RGX_CODE_SYNC_NEG)
      |=> (o_eq_profile_sel[1] == $past(pins_s[NUM_SRC-1])))
    else $error("eq profile bit order wrong");
endmodule
`default_nettype wire

// file: rtl/rgx_defines.svh
// constants for the receive pin crossbar: register offsets, pin codes, reset values
`ifndef RGX_DEFINES_SVH
`define RGX_DEFINES_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define RGX_ADDR_HOP_WORD_B0   15'h37cc
`define RGX_ADDR_HOP_WORD_B1   15'h37cd
`define RGX_ADDR_HOP_WORD_B2   15'h37ce
`define RGX_ADDR_HOP_WORD_B3   15'h37cf
`define RGX_ADDR_HOP_PAGE_B1   15'h37d0
`define RGX_ADDR_HOP_PAGE_B0   15'h37d1
`define RGX_ADDR_FD_GATE       15'h37d4
`define RGX_ADDR_EQ_B0         15'h37d5
`define RGX_ADDR_EQ_B1         15'h37d6
`define RGX_ADDR_ADC1_PWR      15'h37d7
`define RGX_ADDR_ADC3_PWR      15'h37d8

// ------------------------------------------------------------
// pin codes and reset value
// ------------------------------------------------------------
`define RGX_CODE_FIRST_GPIO    8'h02
`define RGX_CODE_LAST_GPIO     8'h06
`define RGX_CODE_SYNC_POS      8'h07
`define RGX_CODE_SYNC_NEG      8'h08
`define RGX_SEL_RESET          8'h00
`define RGX_READ_UNMAPPED      8'h00

`endif

// file: rtl/rgx_pkg.sv
// types shared by the receive pin crossbar
package rgx_pkg;
  typedef enum logic [3:0] {
    RGX_F_HOP_WORD_B0,
    RGX_F_HOP_WORD_B1,
    RGX_F_HOP_WORD_B2,
    RGX_F_HOP_WORD_B3,
    RGX_F_HOP_PAGE_B1,
    RGX_F_HOP_PAGE_B0,
    RGX_F_FD_GATE,
    RGX_F_EQ_B0,
    RGX_F_EQ_B1,
    RGX_F_ADC1_PWR,
    RGX_F_ADC3_PWR
  } rgx_func_t;
endpackage

// file: rtl/rgx_pin_sync.sv
// three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
`default_nettype none
module rgx_pin_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             i_clock,
  input  wire logic             i_srst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  // a change counts only once stages two and three agree
  assign out_d = (s2_q == s3_q) ? s3_q : out_q;
  assign o_sync = out_q;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= i_async;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end
endmodule
`default_nettype wire

// file: dv/rgx_pin_driver.sv
// external controller model that drives the crossbar pins
`timescale 1ns/1ps
`default_nettype none
module rgx_pin_driver (
  input  wire logic       i_clock,
  input  wire logic [6:0] i_level,
  output logic      [4:0] o_gpio,
  output logic            o_sync_pos,
  output logic            o_sync_neg
);
  // pins move on the falling edge, half a cycle away from the sampling edge
  always @(negedge i_clock) begin
    {o_sync_neg, o_sync_pos, o_gpio} <= i_level;
  end
endmodule
`default_nettype wire

// file: dv/test_rgx_input_crossbar.sv
// self-checking bench for the receive pin crossbar
`timescale 1ns/1ps
`default_nettype none
`include "rgx_defines.svh"
module test_rgx_input_crossbar;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [14:0] addr = 15'h0000;
  logic        wr = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [6:0]  level = 7'h00;
  logic        pin_mode = 1'b1;
  logic [1:0]  page_reg = 2'h0;
  logic [3:0]  word_reg = 4'h0;
  logic [3:0]  raw = 4'h0;
  logic [7:0]  rdata, rd;
  logic [4:0]  gpio;
  logic        spos, sneg, gate, adc1, adc3;
  logic [1:0]  page, eq;
  logic [3:0]  word, fd;
  logic [7:0]  sel [11];
  logic [14:0] amap [11] = '{`RGX_ADDR_HOP_WORD_B0, `RGX_ADDR_HOP_WORD_B1, `RGX_ADDR_HOP_WORD_B2,
    `RGX_ADDR_HOP_WORD_B3, `RGX_ADDR_HOP_PAGE_B1, `RGX_ADDR_HOP_PAGE_B0, `RGX_ADDR_FD_GATE,
    `RGX_ADDR_EQ_B0, `RGX_ADDR_EQ_B1, `RGX_ADDR_ADC1_PWR, `RGX_ADDR_ADC3_PWR};
  int          fail_count = 0;
  int          n_checks = 0;
  integer      seed = 23;

  always #2.5 clock = ~clock;

  rgx_pin_driver rgx_pin_driver_i (.i_clock(clock), .i_level(level), .o_gpio(gpio),
    .o_sync_pos(spos), .o_sync_neg(sneg));
  rgx_input_crossbar rgx_input_crossbar_i (.i_clock(clock), .i_srst(srst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_gpio(gpio),
    .i_sync_in_positive_pin(spos), .i_sync_in_negative_pin(sneg),
    .i_rx_hop_pin_mode(pin_mode), .i_rx_hop_page_reg(page_reg), .i_rx_hop_word_reg(word_reg),
    .i_fast_detect_raw(raw), .o_rx_hop_page(page), .o_rx_hop_word(word),
    .o_fast_detect_update_gate(gate), .o_fast_detect(fd), .o_eq_profile_sel(eq),
    .o_adc1_power_control(adc1), .o_adc3_power_control(adc3));

  // undocumented codes leave the function low
  function automatic logic pin_of(input logic [7:0] code, input logic [6:0] lv);
    if (code >= 8'h02 && code <= 8'h08) return lv[code - 8'h02];
    return 1'b0;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [14:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    wr = 1'b1;
    wdata = d;
    @(negedge clock);
    wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [14:0] a, output logic [7:0] d);
    @(negedge clock);
    addr = a;
    @(negedge clock);
    d = rdata;
  endtask

  task automatic check_funcs();
    logic [1:0] ep;
    logic [3:0] ew;
    ep = pin_mode ? {pin_of(sel[4], level), pin_of(sel[5], level)} : page_reg;
    ew = pin_mode ? {pin_of(sel[3], level), pin_of(sel[2], level), pin_of(sel[1], level),
      pin_of(sel[0], level)} : word_reg;
    check({6'h00, page}, {6'h00, ep});
    check({4'h0, word}, {4'h0, ew});
    check({7'h00, gate}, {7'h00, pin_of(sel[6], level)});
    check({6'h00, eq}, {6'h00, pin_of(sel[8], level), pin_of(sel[7], level)});
    check({6'h00, adc3, adc1}, {6'h00, pin_of(sel[10], level), pin_of(sel[9], level)});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(negedge clock);
    srst = 1'b0;
    for (int i = 0; i < 11; i++) begin
      reg_rd(amap[i], rd);
      check(rd, `RGX_SEL_RESET);
    end
    reg_wr(15'h37d2, 8'h05);
    reg_rd(15'h37d2, rd);
    check(rd, `RGX_READ_UNMAPPED);
    $display("test reset_and_unmapped done");
    // first 11 passes walk codes 0 to 10 through every function, then random codes 0 to 15
    for (int n = 0; n < 40; n++) begin
      for (int i = 0; i < 11; i++) begin
        sel[i] = (n < 11) ? 8'((n + i) % 11) : 8'($random(seed) & 8'h0f);
        reg_wr(amap[i], sel[i]);
      end
      for (int i = 0; i < 11; i++) begin
        reg_rd(amap[i], rd);
        check(rd, sel[i]);
      end
      pin_mode = n[0];
      page_reg = 2'($random(seed));
      word_reg = 4'($random(seed));
      level = 7'($random(seed));
      repeat (7) @(negedge clock);
      check_funcs();
      level = ~level;
      repeat (7) @(negedge clock);
      check_funcs();
    end
    $display("test routing done");
    sel[6] = 8'h07;
    reg_wr(amap[6], sel[6]);
    level = 7'h20;
    raw = 4'ha;
    repeat (7) @(negedge clock);
    check({4'h0, fd}, 8'h0a);
    level = 7'h00;
    repeat (7) @(negedge clock);
    raw = 4'h5;
    repeat (3) @(negedge clock);
    check({4'h0, fd}, 8'h0a);
    level = 7'h20;
    repeat (7) @(negedge clock);
    check({4'h0, fd}, 8'h05);
    $display("test fast_detect_gate done");
    // mid-run reset clears every select and function
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    check({4'h0, fd}, 8'h00);
    for (int i = 0; i < 11; i++) begin
      sel[i] = `RGX_SEL_RESET;
      reg_rd(amap[i], rd);
      check(rd, sel[i]);
    end
    check_funcs();
    $display("test mid_run_reset done");
    results();
  end

  // the run needs about 2400 cycles; this bound leaves wide margin
  initial begin
    #100000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
